// File: adcsq_defines.vh
// Constants for the converter sequencer, sample/hold and quick-trip block
`ifndef ADCSQ_DEFINES_VH
`define ADCSQ_DEFINES_VH
`define ADCSQ_MIN_DIV      8'h08
`define ADCSQ_CONV_TICKS   4'hf
`define ADCSQ_PROC_CYC     3'h4
`define ADCSQ_ACQ_TICKS    8'h02
`define ADCSQ_BUF_N        24
`define ADCSQ_VCH_N        16
`define ADCSQ_CFG_W        10
`define ADCSQ_CFG_SRC_LSB  0
`define ADCSQ_CFG_DIFF     5
`define ADCSQ_CFG_ALIGN    6
`define ADCSQ_CFG_ACQX     7
`define ADCSQ_CFG_RNG_LSB  8
`define ADCSQ_BUF_DIE      5'h10
`define ADCSQ_BUF_RT0      5'h11
`define ADCSQ_BUF_RT1      5'h12
`define ADCSQ_BUF_SH0      5'h16
`define ADCSQ_BUF_SH1      5'h17
`define ADCSQ_SRC_SH0      5'h02
`define ADCSQ_SRC_SH1      5'h0c
`define ADCSQ_SRC_RT0      5'h08
`define ADCSQ_SRC_RT1      5'h0a
`define ADCSQ_SRC_DIE      5'h10
`define ADCSQ_HOLD_EN0     0
`define ADCSQ_HOLD_EN1     1
`define ADCSQ_HOLD_DUAL    2
`define ADCSQ_FS_R1_MV     13'h04b0
`define ADCSQ_FS_R2_MV     13'h0258
`define ADCSQ_FS_R3_MV     13'h0960
`define ADCSQ_FS_R4_MV     13'h12c0
`define ADCSQ_QT_SETTLE    4'h3
`define ADCSQ_JOB_VOLT     2'h0
`define ADCSQ_JOB_SH0      2'h1
`define ADCSQ_JOB_SH1      2'h2
`define ADCSQ_JOB_TEMP     2'h3
`endif

// File: adcsq_top.v
// Converter sequencer with sample/hold, temperature, quick-trip and result FIFO
// Operation
// - Mux selects 16 single-ended, 8 differential pins, or internal sources.
// - Continuous mode polls channels; single mode runs one burst then shuts down.
// - Four full-scale ranges, each with own gain trim, 1.2/0.6/2.4/4.8 V.
// - Conversion clock divides core clock by programmed ratio, minimum eight.
// - Conversion takes 15 conversion clocks plus four core clocks processing.
// - Each channel converted twice; only the average is stored.
// - Acquisition extension sets sampling phase to programmed duration instead of two ticks.
// - Per-channel config: differential, alignment, acquisition extension, range.
// - Twenty-four addressable 16-bit result buffers, indices 0 to 23.
// - Data-available flag sets after a programmed sample count.
// - Data-available flag clears on software clear or new sequence start.
// - Two sample/hold channels each enabled by their own control bit.
// - Trigger captures enabled sample/hold input, converts, stores to reserved entry.
// - Dual select makes both sample/holds capture on one trigger or separately.
// - Each sample/hold sets its own done flag, cleared only by software.
// - Die and two remote temperature channels enabled independently.
// - Each temperature conversion sets its own done flag, software cleared.
// - Temperature results carry one sixteenth degree Celsius per LSB.
// - Converter time-sliced among voltage, sample/hold and temperature work.
// - Quick-trip cycles round robin over channel list, high and low compare.
// - Threshold violation sets status bit; sixteen low, sixteen high thresholds.
// - Quick-trip and converter arbitrated so pin accesses never collide.
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_defines.vh"

module adcsq_fifo #(
    parameter WIDTH = 21,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wp_r;
    reg [AW-1:0]    rp_r;
    reg [AW:0]      cnt_r;
    wire            push = in_valid && in_ready;
    wire            pop  = out_valid && out_ready;
    assign in_ready  = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data  = mem[rp_r];
    always @(posedge ref_clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
            if (pop)  rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
            if (push && !pop) cnt_r <= cnt_r + 1'b1;
            else if (pop && !push) cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule // adcsq_fifo

module adcsq_top #(
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW    = 5
) (
    input  wire         ref_clk,
    input  wire         rst,
    input  wire         seq_start,
    input  wire         continuous_mode,
    input  wire [3:0]   first_chan,
    input  wire [3:0]   last_chan,
    input  wire [159:0] chan_cfg,
    input  wire [7:0]   conv_clk_div,
    input  wire [7:0]   acq_ext_ticks,
    input  wire [7:0]   daf_sample_count,
    input  wire         daf_clear,
    input  wire [15:0]  gain_trim_range1,
    input  wire [15:0]  gain_trim_range2,
    input  wire [15:0]  gain_trim_range3,
    input  wire [15:0]  gain_trim_range4,
    input  wire [12:0]  conv_result_in,
    input  wire [2:0]   hold_ctrl_reg,
    input  wire         hold_trigger_pin,
    input  wire [1:0]   hold_flag_clear,
    input  wire [2:0]   temp_ctrl_reg,
    input  wire [2:0]   temp_flag_clear,
    input  wire         qt_enable,
    input  wire [15:0]  qt_chan_list,
    input  wire [127:0] qt_high_thr,
    input  wire [127:0] qt_low_thr,
    input  wire         qt_cmp_in,
    input  wire [15:0]  qt_high_clear,
    input  wire [15:0]  qt_low_clear,
    input  wire [4:0]   rd_addr,
    output reg  [15:0]  rd_data_r,
    input  wire         res_ready,
    output reg          res_valid_r,
    output reg  [20:0]  res_data_r,
    output reg          conv_clock_r,
    output reg  [4:0]   conv_mux_sel_r,
    output reg          conv_diff_r,
    output reg  [1:0]   conv_range_r,
    output reg  [15:0]  conv_gain_trim_r,
    output reg  [12:0]  conv_fullscale_r,
    output reg  [1:0]   conv_temp_mode_r,
    output reg          conv_sample_r,
    output reg          conv_start_r,
    output reg          conv_shutdown_r,
    output reg  [1:0]   hold_capture_r,
    output reg          conv_data_avail_flag,
    output reg  [1:0]   hold_data_avail_flag,
    output reg          die_temp_done_flag,
    output reg          remote0_temp_done_flag,
    output reg          remote1_temp_done_flag,
    output reg  [3:0]   qt_mux_sel_r,
    output reg  [7:0]   qt_thr_r,
    output reg          qt_strobe_r,
    output reg  [15:0]  qt_high_status_r,
    output reg  [15:0]  qt_low_status_r
);
    localparam ST_IDLE = 3'h0;
    localparam ST_SAMP = 3'h1;
    localparam ST_CONV = 3'h2;
    localparam ST_PROC = 3'h3;
    localparam ST_WB   = 3'h4;

    reg [15:0] buf_mem [0:`ADCSQ_BUF_N-1];
    reg [2:0]  state_r;
    reg [6:0]  div_cnt_r;
    reg [7:0]  tick_cnt_r;
    reg [2:0]  proc_cnt_r;
    reg [1:0]  job_kind_r;
    reg [1:0]  job_tsel_r;
    reg [4:0]  job_buf_r;
    reg [9:0]  job_cfg_r;
    reg        pass_r;
    reg [12:0] first_r;
    reg [12:0] second_r;
    reg [3:0]  vch_r;
    reg        seq_run_r;
    reg        slice_r;
    reg [1:0]  tptr_r;
    reg [1:0]  hold_pend_r;
    reg        hold_alt_r;
    reg        trig_prev_r;
    reg [7:0]  smp_cnt_r;
    reg [3:0]  qt_ch_r;
    reg        qt_ph_r;
    reg [3:0]  qt_set_r;

    // Effective divider never faster than the minimum ratio
    wire [7:0]  eff_div  = (conv_clk_div < `ADCSQ_MIN_DIV) ? `ADCSQ_MIN_DIV : conv_clk_div;
    wire        half_end = (div_cnt_r == eff_div[7:1] - 7'h01);
    wire        tick     = half_end && !conv_clock_r;
    wire        trig_evt = hold_trigger_pin && !trig_prev_r;
    wire [13:0] sum      = {1'b0, first_r} + {1'b0, second_r};
    wire [12:0] avg      = sum[13:1];
    wire [9:0]  vcfg     = chan_cfg[vch_r*`ADCSQ_CFG_W +: `ADCSQ_CFG_W];
    wire [7:0]  acq_len  = job_cfg_r[`ADCSQ_CFG_ACQX] ? acq_ext_ticks : `ADCSQ_ACQ_TICKS;
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [20:0] fifo_out_data;
    wire        fifo_pop = fifo_out_valid && (!res_valid_r || res_ready);
    reg  [15:0] wb_data;
    reg  [1:0]  tnext;
    reg         have_t;

    // Result formatting: alignment, sign extension for differential and temperature
    always @* begin
        if (job_kind_r == `ADCSQ_JOB_TEMP) begin
            wb_data = {{3{avg[12]}}, avg};
        end else if (job_cfg_r[`ADCSQ_CFG_ALIGN]) begin
            wb_data = {avg, 3'h0};
        end else if (job_cfg_r[`ADCSQ_CFG_DIFF]) begin
            wb_data = {{3{avg[12]}}, avg};
        end else begin
            wb_data = {3'h0, avg};
        end
    end

    // Next enabled temperature channel after the last one served
    always @* begin
        have_t = 1'b0;
        tnext  = 2'h0;
        if (temp_ctrl_reg[(tptr_r + 2'h1) % 3]) begin
            have_t = 1'b1;
            tnext  = (tptr_r == 2'h2) ? 2'h0 : tptr_r + 2'h1;
        end else if (temp_ctrl_reg[(tptr_r + 2'h2) % 3]) begin
            have_t = 1'b1;
            tnext  = (tptr_r == 2'h0) ? 2'h2 : tptr_r - 2'h1;
        end else if (temp_ctrl_reg[tptr_r]) begin
            have_t = 1'b1;
            tnext  = tptr_r;
        end
    end

    function [3:0] qt_next;
        input [3:0]  cur;
        input [15:0] list;
        integer      k;
        reg          found;
        begin
            qt_next = cur;
            found   = 1'b0;
            for (k = 1; k <= 16; k = k + 1) begin
                if (!found && list[(cur + k) % 16]) begin
                    qt_next = cur + k[3:0];
                    found   = 1'b1;
                end
            end
        end
    endfunction

    adcsq_fifo #(
        .WIDTH (21),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (state_r == ST_WB),
        .in_ready  (fifo_in_ready),
        .in_data   ({job_buf_r, wb_data}),
        .out_valid (fifo_out_valid),
        .out_ready (!res_valid_r || res_ready),
        .out_data  (fifo_out_data)
    );

    always @(posedge ref_clk) begin
        if (state_r == ST_WB && fifo_in_ready) begin
            buf_mem[job_buf_r] <= wb_data;
        end
        rd_data_r <= (rd_addr < `ADCSQ_BUF_N) ? buf_mem[rd_addr] : 16'h0000;
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            div_cnt_r <= 7'h00;
            tick_cnt_r <= 8'h00;
            proc_cnt_r <= 3'h0;
            job_kind_r <= `ADCSQ_JOB_VOLT;
            job_tsel_r <= 2'h0;
            job_buf_r <= 5'h00;
            job_cfg_r <= 10'h000;
            pass_r <= 1'b0;
            first_r <= 13'h0000;
            second_r <= 13'h0000;
            vch_r <= 4'h0;
            seq_run_r <= 1'b0;
            slice_r <= 1'b0;
            tptr_r <= 2'h2;
            hold_pend_r <= 2'h0;
            hold_alt_r <= 1'b0;
            trig_prev_r <= 1'b0;
            smp_cnt_r <= 8'h00;
            res_valid_r <= 1'b0;
            res_data_r <= 21'h000000;
            conv_clock_r <= 1'b0;
            conv_mux_sel_r <= 5'h00;
            conv_diff_r <= 1'b0;
            conv_range_r <= 2'h0;
            conv_gain_trim_r <= 16'h0000;
            conv_fullscale_r <= 13'h0000;
            conv_temp_mode_r <= 2'h0;
            conv_sample_r <= 1'b0;
            conv_start_r <= 1'b0;
            conv_shutdown_r <= 1'b1;
            hold_capture_r <= 2'h0;
            conv_data_avail_flag <= 1'b0;
            hold_data_avail_flag <= 2'h0;
            die_temp_done_flag <= 1'b0;
            remote0_temp_done_flag <= 1'b0;
            remote1_temp_done_flag <= 1'b0;
        end else begin
            conv_start_r <= 1'b0;
            trig_prev_r <= hold_trigger_pin;
            if (fifo_pop) begin
                res_valid_r <= 1'b1;
                res_data_r <= fifo_out_data;
            end else if (res_ready) begin
                res_valid_r <= 1'b0;
            end
            // Conversion clock divider, stopped in shutdown
            if (conv_shutdown_r || half_end) begin
                div_cnt_r <= 7'h00;
            end else begin
                div_cnt_r <= div_cnt_r + 7'h01;
            end
            if (conv_shutdown_r) begin
                conv_clock_r <= 1'b0;
            end else if (half_end) begin
                conv_clock_r <= !conv_clock_r;
            end
            // Trigger captures into sample/hold; pending conversion follows
            hold_capture_r <= 2'h0;
            if (trig_evt) begin
                if (hold_ctrl_reg[`ADCSQ_HOLD_DUAL] || hold_ctrl_reg[1:0] != 2'h3) begin
                    hold_capture_r <= hold_ctrl_reg[1:0];
                    hold_pend_r <= hold_pend_r | hold_ctrl_reg[1:0];
                end else begin
                    hold_capture_r <= hold_alt_r ? 2'h2 : 2'h1;
                    hold_pend_r <= hold_pend_r | (hold_alt_r ? 2'h2 : 2'h1);
                    hold_alt_r <= !hold_alt_r;
                end
            end
            // Software clears, set wins below
            if (daf_clear || seq_start) conv_data_avail_flag <= 1'b0;
            hold_data_avail_flag <= hold_data_avail_flag & ~hold_flag_clear;
            if (temp_flag_clear[0]) die_temp_done_flag <= 1'b0;
            if (temp_flag_clear[1]) remote0_temp_done_flag <= 1'b0;
            if (temp_flag_clear[2]) remote1_temp_done_flag <= 1'b0;
            if (seq_start) begin
                seq_run_r <= 1'b1;
                vch_r <= first_chan;
                smp_cnt_r <= 8'h00;
                conv_shutdown_r <= 1'b0;
            end
            case (state_r)
                ST_IDLE: begin
                    tick_cnt_r <= 8'h00;
                    pass_r <= 1'b0;
                    conv_temp_mode_r <= 2'h0;
                    // Time slice: sample/hold first, then temperature and voltage alternate
                    if (hold_pend_r != 2'h0) begin
                        job_kind_r <= hold_pend_r[0] ? `ADCSQ_JOB_SH0 : `ADCSQ_JOB_SH1;
                        job_buf_r <= hold_pend_r[0] ? `ADCSQ_BUF_SH0 : `ADCSQ_BUF_SH1;
                        conv_mux_sel_r <= hold_pend_r[0] ? `ADCSQ_SRC_SH0 : `ADCSQ_SRC_SH1;
                        job_cfg_r <= 10'h020;
                        conv_diff_r <= 1'b1;
                        hold_pend_r <= hold_pend_r[0] ? {hold_pend_r[1], 1'b0} : 2'h0;
                        state_r <= ST_SAMP;
                        conv_shutdown_r <= 1'b0;
                    end else if (have_t && (slice_r || !seq_run_r)) begin
                        job_kind_r <= `ADCSQ_JOB_TEMP;
                        job_tsel_r <= tnext;
                        tptr_r <= tnext;
                        job_buf_r <= (tnext == 2'h0) ? `ADCSQ_BUF_DIE :
                                     (tnext == 2'h1) ? `ADCSQ_BUF_RT0 : `ADCSQ_BUF_RT1;
                        conv_mux_sel_r <= (tnext == 2'h0) ? `ADCSQ_SRC_DIE :
                                          (tnext == 2'h1) ? `ADCSQ_SRC_RT0 : `ADCSQ_SRC_RT1;
                        conv_temp_mode_r <= tnext + 2'h1;
                        job_cfg_r <= 10'h000;
                        conv_diff_r <= (tnext != 2'h0);
                        slice_r <= 1'b0;
                        state_r <= ST_SAMP;
                        conv_shutdown_r <= 1'b0;
                    end else if (seq_run_r && !seq_start) begin
                        job_kind_r <= `ADCSQ_JOB_VOLT;
                        job_buf_r <= {1'b0, vch_r};
                        job_cfg_r <= vcfg;
                        conv_mux_sel_r <= vcfg[`ADCSQ_CFG_SRC_LSB +: 5];
                        conv_diff_r <= vcfg[`ADCSQ_CFG_DIFF];
                        slice_r <= 1'b1;
                        state_r <= ST_SAMP;
                    end else if (!seq_start) begin
                        conv_shutdown_r <= 1'b1;
                        conv_clock_r <= 1'b0;
                    end
                end
                ST_SAMP: begin
                    conv_sample_r <= 1'b1;
                    conv_range_r <= job_cfg_r[`ADCSQ_CFG_RNG_LSB +: 2];
                    case (job_cfg_r[`ADCSQ_CFG_RNG_LSB +: 2])
                        2'h0: begin
                            conv_gain_trim_r <= gain_trim_range1;
                            conv_fullscale_r <= `ADCSQ_FS_R1_MV;
                        end
                        2'h1: begin
                            conv_gain_trim_r <= gain_trim_range2;
                            conv_fullscale_r <= `ADCSQ_FS_R2_MV;
                        end
                        2'h2: begin
                            conv_gain_trim_r <= gain_trim_range3;
                            conv_fullscale_r <= `ADCSQ_FS_R3_MV;
                        end
                        default: begin
                            conv_gain_trim_r <= gain_trim_range4;
                            conv_fullscale_r <= `ADCSQ_FS_R4_MV;
                        end
                    endcase
                    if (tick) begin
                        if (tick_cnt_r + 8'h01 >= acq_len) begin
                            tick_cnt_r <= 8'h00;
                            conv_sample_r <= 1'b0;
                            conv_start_r <= 1'b1;
                            state_r <= ST_CONV;
                        end else begin
                            tick_cnt_r <= tick_cnt_r + 8'h01;
                        end
                    end
                end
                ST_CONV: begin
                    if (tick) begin
                        if (tick_cnt_r[3:0] == `ADCSQ_CONV_TICKS - 4'h1) begin
                            tick_cnt_r <= 8'h00;
                            proc_cnt_r <= 3'h0;
                            if (pass_r) second_r <= conv_result_in;
                            else first_r <= conv_result_in;
                            state_r <= ST_PROC;
                        end else begin
                            tick_cnt_r <= tick_cnt_r + 8'h01;
                        end
                    end
                end
                ST_PROC: begin
                    if (proc_cnt_r == `ADCSQ_PROC_CYC - 3'h1) begin
                        pass_r <= 1'b1;
                        state_r <= pass_r ? ST_WB : ST_SAMP;
                    end else begin
                        proc_cnt_r <= proc_cnt_r + 3'h1;
                    end
                end
                ST_WB: begin
                    if (fifo_in_ready) begin
                        state_r <= ST_IDLE;
                        case (job_kind_r)
                            `ADCSQ_JOB_SH0: hold_data_avail_flag[0] <= 1'b1;
                            `ADCSQ_JOB_SH1: hold_data_avail_flag[1] <= 1'b1;
                            `ADCSQ_JOB_TEMP: begin
                                if (job_tsel_r == 2'h0) die_temp_done_flag <= 1'b1;
                                if (job_tsel_r == 2'h1) remote0_temp_done_flag <= 1'b1;
                                if (job_tsel_r == 2'h2) remote1_temp_done_flag <= 1'b1;
                            end
                            default: begin
                                if (smp_cnt_r + 8'h01 >= daf_sample_count) begin
                                    smp_cnt_r <= 8'h00;
                                    conv_data_avail_flag <= 1'b1;
                                end else begin
                                    smp_cnt_r <= smp_cnt_r + 8'h01;
                                end
                                if (vch_r == last_chan) begin
                                    vch_r <= first_chan;
                                    seq_run_r <= continuous_mode;
                                end else begin
                                    vch_r <= vch_r + 4'h1;
                                end
                            end
                        endcase
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Quick-trip round robin; frozen while the converter samples the shared pins
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            qt_ch_r <= 4'h0;
            qt_ph_r <= 1'b0;
            qt_set_r <= 4'h0;
            qt_mux_sel_r <= 4'h0;
            qt_thr_r <= 8'h00;
            qt_strobe_r <= 1'b0;
            qt_high_status_r <= 16'h0000;
            qt_low_status_r <= 16'h0000;
        end else begin
            qt_strobe_r <= 1'b0;
            qt_high_status_r <= qt_high_status_r & ~qt_high_clear;
            qt_low_status_r <= qt_low_status_r & ~qt_low_clear;
            qt_mux_sel_r <= qt_ch_r;
            qt_thr_r <= qt_ph_r ? qt_low_thr[qt_ch_r*8 +: 8] : qt_high_thr[qt_ch_r*8 +: 8];
            if (!qt_enable || qt_chan_list == 16'h0000 || !qt_chan_list[qt_ch_r]) begin
                qt_set_r <= 4'h0;
                qt_ph_r <= 1'b0;
                if (qt_chan_list != 16'h0000) qt_ch_r <= qt_next(qt_ch_r, qt_chan_list);
            end else if (!conv_sample_r && state_r != ST_SAMP) begin
                if (qt_set_r == `ADCSQ_QT_SETTLE) begin
                    qt_set_r <= 4'h0;
                    qt_strobe_r <= 1'b1;
                    if (!qt_ph_r && qt_cmp_in) qt_high_status_r[qt_ch_r] <= 1'b1;
                    if (qt_ph_r && !qt_cmp_in) qt_low_status_r[qt_ch_r] <= 1'b1;
                    qt_ph_r <= !qt_ph_r;
                    if (qt_ph_r) qt_ch_r <= qt_next(qt_ch_r, qt_chan_list);
                end else begin
                    qt_set_r <= qt_set_r + 4'h1;
                end
            end
        end
    end
endmodule // adcsq_top
`default_nettype wire

// File: adcsq_chk.sv
// Port checker for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adcsq_chk (
    input wire logic       ref_clk, rst, seq_start, conv_shutdown_r, conv_sample_r, conv_start_r, conv_clock_r,
    input wire logic       conv_data_avail_flag, die_temp_done_flag, qt_strobe_r, hold_trigger_pin,
    input wire logic [2:0] hold_ctrl_reg, temp_flag_clear,
    input wire logic [1:0] hold_capture_r, hold_data_avail_flag, hold_flag_clear,
    input wire logic [4:0] rd_addr,
    input wire logic [15:0] rd_data_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_start_wakes: assert property (seq_start |=> !conv_shutdown_r) else $error("no wake");
    a_idle_clock: assert property (conv_shutdown_r |-> !conv_clock_r) else $error("clock in idle");
    a_sample_soon: assert property (seq_start && conv_shutdown_r |-> ##3 conv_sample_r) else $error("late");
    a_start_ends: assert property (conv_start_r |-> !conv_sample_r) else $error("overlap");
    a_flag_clears: assert property (seq_start |=> !conv_data_avail_flag) else $error("flag kept");
    a_hold_sticky: assert property ($fell(hold_data_avail_flag[0]) |-> $past(hold_flag_clear[0])) else $error("drop");
    a_temp_sticky: assert property ($fell(die_temp_done_flag) |-> $past(temp_flag_clear[0])) else $error("drop");
    a_dual_grab: assert property ($rose(hold_trigger_pin) && hold_ctrl_reg == 3'h7 |-> ##[0:1] hold_capture_r == 2'h3)
        else $error("dual miss");
    a_rd_empty: assert property (rd_addr > 5'h17 |=> rd_data_r == 16'h0) else $error("bad read");
    a_qt_frozen: assert property (conv_sample_r |-> !qt_strobe_r) else $error("collision");
    cover property (conv_data_avail_flag);
    cover property (hold_capture_r == 2'h3);
    cover property (qt_strobe_r);
endmodule // adcsq_chk
`default_nettype wire

// File: adcsq_model.sv
// Converter and comparator stand-in
`timescale 1ns/1ps
`default_nettype none
module adcsq_model (
    input wire logic       ref_clk, conv_start_r,
    input wire logic [4:0] conv_mux_sel_r,
    input wire logic [7:0] qt_thr_r,
    output logic [12:0]    conv_result_in,
    output logic           qt_cmp_in
);
    initial conv_result_in = 13'h0;
    // Code names its source so each buffer entry shows where it came from
    always @(posedge ref_clk) if (conv_start_r) conv_result_in <= {8'h01, conv_mux_sel_r};
    assign qt_cmp_in = qt_thr_r < 8'h80;
endmodule // adcsq_model
`default_nettype wire

// File: adcsq_top_bench.sv
// Bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adcsq_top_bench;
    logic ref_clk = 0, rst = 1, seq_start = 0, continuous_mode = 0, daf_clear = 0, hold_trigger_pin = 0;
    logic qt_enable = 0, res_ready = 1, qt_cmp_in;
    logic [3:0] first_chan = 4'h3, last_chan = 4'h3;
    logic [159:0] chan_cfg = 160'h3 << 30;
    logic [7:0] conv_clk_div = 8'h08, acq_ext_ticks = 8'h02, daf_sample_count = 8'h01;
    logic [15:0] gain_trim_range1 = 16'h0, gain_trim_range2 = 16'h0, gain_trim_range3 = 16'h0, gain_trim_range4 = 16'h0;
    logic [2:0] hold_ctrl_reg = 3'h0, temp_ctrl_reg = 3'h0, temp_flag_clear = 3'h0;
    logic [15:0] qt_chan_list = 16'h2, qt_high_clear = 16'h0, qt_low_clear = 16'h0;
    logic [127:0] qt_high_thr = 128'h4000, qt_low_thr = 128'h2000;
    logic [4:0] rd_addr = 5'h0, conv_mux_sel_r;
    logic [1:0] hold_flag_clear = 2'h0, conv_range_r, conv_temp_mode_r, hold_capture_r, hold_data_avail_flag;
    logic [20:0] res_data_r;
    logic [15:0] rd_data_r, conv_gain_trim_r, qt_high_status_r, qt_low_status_r;
    logic [12:0] conv_result_in, conv_fullscale_r;
    logic [7:0] qt_thr_r;
    logic [3:0] qt_mux_sel_r;
    logic res_valid_r, conv_clock_r, conv_diff_r, conv_sample_r, conv_start_r, conv_shutdown_r, conv_data_avail_flag;
    logic die_temp_done_flag, remote0_temp_done_flag, remote1_temp_done_flag, qt_strobe_r;
    int fail_count = 0, checks_done = 0;
    adcsq_top DUT (.*);
    adcsq_model M (.*);
    task chk(input string n, input logic [20:0] e, g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task rd(input logic [4:0] a);
        rd_addr = a;
        repeat (2) @(negedge ref_clk);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task t_volt;
        seq_start = 1;
        @(negedge ref_clk) seq_start = 0;
        repeat (3000) if (!res_valid_r) @(negedge ref_clk);
        chk("res", {5'h03, 16'h0023}, res_data_r);
        repeat (20) @(negedge ref_clk);
        chk("daf", 1, conv_data_avail_flag);
        chk("idle", 1, conv_shutdown_r);
        rd(5'h03); chk("buf3", 16'h0023, rd_data_r);
        daf_clear = 1;
        @(negedge ref_clk) daf_clear = 0;
        rd(5'h18); chk("buf24", 0, rd_data_r);
        chk("daf clr", 0, conv_data_avail_flag);
        $display("test volt done");
    endtask
    task t_hold;
        hold_ctrl_reg = 3'h7;
        hold_trigger_pin = 1;
        repeat (3) if (hold_capture_r == 2'h0) @(negedge ref_clk);
        chk("capture", 2'h3, hold_capture_r);
        hold_trigger_pin = 0;
        repeat (6000) if (hold_data_avail_flag != 2'h3) @(negedge ref_clk);
        chk("hflags", 2'h3, hold_data_avail_flag);
        rd(5'h16); chk("buf22", 16'h0022, rd_data_r);
        rd(5'h17); chk("buf23", 16'h002c, rd_data_r);
        hold_flag_clear = 2'h3;
        @(negedge ref_clk) hold_flag_clear = 2'h0;
        @(negedge ref_clk) chk("hclr", 2'h0, hold_data_avail_flag);
        $display("test hold done");
    endtask
    task t_qt;
        qt_enable = 1;
        repeat (200) if (!qt_high_status_r[1]) @(negedge ref_clk);
        chk("qt high", 1, qt_high_status_r[1]);
        repeat (40) @(negedge ref_clk);
        chk("qt low", 0, qt_low_status_r[1]);
        chk("qt unlisted", 0, qt_high_status_r[0]);
        $display("test quick trip done");
    endtask
    task t_temp;
        temp_ctrl_reg = 3'h1;
        repeat (2000) if (!die_temp_done_flag) @(negedge ref_clk);
        temp_ctrl_reg = 3'h0;
        chk("tflag", 1, die_temp_done_flag);
        rd(5'h10); chk("buf16", 16'h0030, rd_data_r);
        temp_flag_clear = 3'h1;
        @(negedge ref_clk) temp_flag_clear = 3'h0;
        $display("test temp done");
    endtask
    initial forever #5 ref_clk = ~ref_clk;
    initial begin
        repeat (4) @(negedge ref_clk);
        rst = 0;
        @(negedge ref_clk) t_volt;
        t_hold;
        t_qt;
        t_temp;
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        tally_and_finish;
    end
endmodule // adcsq_top_bench
bind adcsq_top adcsq_chk u_chk (.*);
`default_nettype wire
